//--- rtl/cwbs_bit_route.sv
// One control word bit router: picks the fixed or switched source
`timescale 1ns/100ps
module cwbs_bit_route (
    input  wire logic [1:0] kind,      // Assignment kind of this bit
    input  wire logic [2:0] fix_src,   // Fixed source code
    input  wire logic [2:0] act_src,   // Active command channel source
    input  wire logic       reserved,  // Bit held by run mode
    input  wire logic       term_bit,  // Same-order terminal or card input
    input  wire logic       term_ok,   // That input exists
    input  wire logic [3:0] net_bits,  // Same-order bits: serial, can, net, emb
    output logic            value      // Routed function input
);
    // Only the same-order bit is ever offered, so no cross-position routing exists
    function automatic logic pick(input logic [2:0] src);
        case (src)
            cwbs_pkg::SRC_TERM:   pick = term_bit & term_ok;
            cwbs_pkg::SRC_SERIAL: pick = net_bits[0];
            cwbs_pkg::SRC_CAN:    pick = net_bits[1];
            cwbs_pkg::SRC_NET:    pick = net_bits[2];
            cwbs_pkg::SRC_EMB:    pick = net_bits[3];
            default:              pick = 1'b0;
        endcase
    endfunction

    // Reserved bits never reach a function input
    always_comb
    begin
        if (reserved)
            value = 1'b0;                                   // see [R09] [R11]
        else if (kind == cwbs_pkg::KIND_FIXED)
            value = pick(fix_src);                          // see [R08]
        else if (kind == cwbs_pkg::KIND_SWITCHED)
            value = pick(act_src);                          // see [R03] [R13]
        else
            value = 1'b0;
    end
endmodule // cwbs_bit_route

//--- rtl/cwbs_pkg.sv
// Shared constants and types for control word bit switching
package cwbs_pkg;
    localparam int          CW_BITS      = 16;
    localparam int          TERM_BASE_HI = 5;      // Base terminals feed bits 0..5
    localparam int          LOGIC_LO     = 6;      // Logic card feeds bits 6..9
    localparam int          LOGIC_HI     = 9;
    localparam int          EXT_LO       = 10;     // Extended card feeds bits 10..13
    localparam int          EXT_HI       = 13;
    localparam logic [3:0]  FWD_BIT      = 4'h0;   // Forward run, two-wire
    localparam logic [3:0]  AUTH_BIT     = 4'h0;   // Run authorization, three-wire
    localparam logic [3:0]  FWD3_BIT     = 4'h1;   // Forward, three-wire
    localparam logic [3:0]  REV2_BIT     = 4'h1;   // Default reverse bit, two-wire
    localparam logic [3:0]  REV3_BIT     = 4'h2;   // Default reverse bit, three-wire

    // Run command style, one-hot
    typedef enum logic [1:0] {
        two_wire_level_run  = 2'b01,
        three_wire_edge_run = 2'b10
    } cwbs_run_t;

    // Per-bit assignment kind
    typedef enum logic [1:0] {
        KIND_NONE     = 2'h0,
        KIND_FIXED    = 2'h1,
        KIND_SWITCHED = 2'h2
    } cwbs_kind_t;

    // Source of a bit: terminal or card input, or one network control word
    typedef enum logic [2:0] {
        SRC_TERM   = 3'h0,
        SRC_SERIAL = 3'h1,
        SRC_CAN    = 3'h2,
        SRC_NET    = 3'h3,
        SRC_EMB    = 3'h4
    } cwbs_src_t;

    // How a channel switch is driven
    typedef enum logic [1:0] {
        SW_FIX_CH1 = 2'h0,
        SW_FIX_CH2 = 2'h1,
        SW_INPUT   = 2'h2,
        SW_CWBIT   = 2'h3
    } cwbs_swmode_t;

    localparam cwbs_kind_t  KIND_RST = KIND_NONE;
    localparam cwbs_src_t   SRC_RST  = SRC_TERM;
endpackage

//--- rtl/cwbs_top.sv
// Control word bit switching: routes 16 function inputs from their sources
// Notes on behaviour
// [R01] Without separate mode, reference switch drives command
// [R02] Each of 16 bits assigned individually
// [R03] Switched bit takes only same-order source bit
// [R04] Base terminals switch bits 0 to 5
// [R05] Logic card inputs switch bits 6 to 9
// [R06] Extended card inputs switch bits 10 to 13
// [R07] Fixed and switched on one bit rejected
// [R08] Fixed: same-order input or network word bit
// [R09] Two-wire reserves bit 0 as forward run
// [R10] Two-wire default reverse command on bit 1
// [R11] Three-wire reserves bits 0 and 1
// [R12] Three-wire default reverse command on bit 2
// [R13] Switched: terminals or selected network word bit
// [R14] Separate mode switches reference and command independently
// [R15] Switch from input, word bit, or configuration
// [R16] Outputs refresh each cycle from current selection
`timescale 1ns/100ps
module cwbs_top (
    input  wire logic        clk_sys,        // System clock, 200 MHz
    input  wire logic        sys_rst,        // Synchronous reset, active high
    input  wire logic        clk_en,         // Freezes all state while low, except that sys_rst still clears it
    input  wire logic [5:0]  term_in,        // Base terminal inputs, order 0..5
    input  wire logic [3:0]  logic_card_in,  // Logic card inputs, order 6..9
    input  wire logic        logic_card_fit, // Logic card fitted
    input  wire logic [3:0]  ext_card_in,    // Extended card inputs, order 10..13
    input  wire logic        ext_card_fit,   // Extended card fitted
    input  wire logic [15:0] cw_serial,      // Integrated serial control word
    input  wire logic [15:0] cw_can,         // CAN control word
    input  wire logic [15:0] cw_net,         // Network card control word
    input  wire logic [15:0] cw_emb,         // Embedded controller card word
    input  wire logic [1:0]  run_style,      // Two-wire or three-wire, one-hot
    input  wire logic        separate_mode,  // Independent command switching
    input  wire logic [2:0]  command_source_one, // Source of command channel 1
    input  wire logic [2:0]  command_source_two, // Source of command channel 2
    input  wire logic [1:0]  direct_reference_select, // Reference switch mode
    input  wire logic [3:0]  ref_sw_index,   // Input or bit order for it
    input  wire logic [2:0]  ref_sw_word,    // Word carrying its bit
    input  wire logic [1:0]  command_channel_select,  // Command switch mode
    input  wire logic [3:0]  cmd_sw_index,   // Input or bit order for it
    input  wire logic [2:0]  cmd_sw_word,    // Word carrying its bit
    input  wire logic        cfg_wr,         // Assignment write strobe
    input  wire logic [3:0]  cfg_bit,        // Control word bit written
    input  wire logic [1:0]  cfg_kind,       // New kind
    input  wire logic [2:0]  cfg_src,        // Fixed source for a fixed kind
    output logic [15:0]      func_in,        // Routed function inputs
    output logic             ref_ch2,        // Direct reference on channel 2
    output logic             cmd_ch2,        // Command on channel 2
    output logic             run_fwd,        // Forward run command
    output logic             run_auth,       // Run authorization, three-wire
    output logic             reverse_direction_assign, // Reverse command
    output logic             cfg_ack,        // Write taken, one-cycle pulse
    output logic             cfg_reject      // Write refused, one-cycle pulse
);
    typedef struct packed {
        logic [15:0][1:0] kind;
        logic [15:0][2:0] src;
        logic [15:0]      func;
        logic             ref2;
        logic             cmd2;
        logic             fwd;
        logic             auth;
        logic             rev;
        logic             ack;
        logic             rej;
    } cwbs_state_t;

    cwbs_state_t state_q;
    cwbs_state_t state_d;

    logic [15:0] term_vec;
    logic [15:0] term_ok;
    logic [15:0] reserved;
    logic [15:0] routed;
    logic        ref_sel2;
    logic        cmd_sel2;
    logic [2:0]  act_src;
    logic        is_two;
    logic        is_three;

    assign is_two   = (run_style == cwbs_pkg::two_wire_level_run);
    assign is_three = (run_style == cwbs_pkg::three_wire_edge_run);

    // Terminal view by bit order; card inputs exist only when the card does
    always_comb
    begin
        term_vec = 16'h0000;
        term_ok  = 16'h0000;
        term_vec[cwbs_pkg::TERM_BASE_HI:0] = term_in;                     // see [R04]
        term_ok[cwbs_pkg::TERM_BASE_HI:0]  = 6'h3f;                       // see [R04]
        term_vec[cwbs_pkg::LOGIC_HI:cwbs_pkg::LOGIC_LO] = logic_card_in;  // see [R05]
        term_ok[cwbs_pkg::LOGIC_HI:cwbs_pkg::LOGIC_LO]  = {4{logic_card_fit}};
        term_vec[cwbs_pkg::EXT_HI:cwbs_pkg::EXT_LO] = ext_card_in;        // see [R06]
        term_ok[cwbs_pkg::EXT_HI:cwbs_pkg::EXT_LO]  = {4{ext_card_fit}};
    end

    // Bits held by the run style and offered to no function
    always_comb
    begin
        reserved = 16'h0000;
        if (is_two)
            reserved[cwbs_pkg::FWD_BIT] = 1'b1;                          // see [R09]
        if (is_three)
        begin
            reserved[cwbs_pkg::AUTH_BIT] = 1'b1;                         // see [R11]
            reserved[cwbs_pkg::FWD3_BIT] = 1'b1;                         // see [R11]
        end
    end

    // Pick one bit of a network word by source code
    function automatic logic word_bit(input logic [2:0] w, input logic [3:0] i);
        case (w)
            cwbs_pkg::SRC_SERIAL: word_bit = cw_serial[i];
            cwbs_pkg::SRC_CAN:    word_bit = cw_can[i];
            cwbs_pkg::SRC_NET:    word_bit = cw_net[i];
            cwbs_pkg::SRC_EMB:    word_bit = cw_emb[i];
            default:              word_bit = term_vec[i] & term_ok[i];
        endcase
    endfunction

    // Resolve a channel switch to "channel 2 selected"
    function automatic logic sw_ch2(input logic [1:0] m, input logic [3:0] i,
                                    input logic [2:0] w);
        case (m)
            cwbs_pkg::SW_FIX_CH1: sw_ch2 = 1'b0;
            cwbs_pkg::SW_FIX_CH2: sw_ch2 = 1'b1;
            cwbs_pkg::SW_INPUT:   sw_ch2 = term_vec[i] & term_ok[i];
            default:              sw_ch2 = word_bit(w, i);
        endcase
    endfunction

    // Switch values are sampled live so a network rewrite acts at once
    always_comb
    begin
        ref_sel2 = sw_ch2(direct_reference_select, ref_sw_index, ref_sw_word);  // see [R15]
        if (separate_mode)
            cmd_sel2 = sw_ch2(command_channel_select, cmd_sw_index, cmd_sw_word); // see [R14]
        else
            cmd_sel2 = ref_sel2;                                           // see [R01]
        act_src = cmd_sel2 ? command_source_two : command_source_one;      // see [R13]
    end

    // One router per control word bit
    genvar g;
    generate
        for (g = 0; g < cwbs_pkg::CW_BITS; g++)
        begin : g_bit
            cwbs_bit_route u_route (
                .kind     (state_q.kind[g]),
                .fix_src  (state_q.src[g]),
                .act_src  (act_src),
                .reserved (reserved[g]),
                .term_bit (term_vec[g]),
                .term_ok  (term_ok[g]),
                .net_bits ({cw_emb[g], cw_net[g], cw_can[g], cw_serial[g]}),
                .value    (routed[g])
            );                                                             // see [R02]
        end
    endgenerate

    // Next state: configuration writes, routed outputs, run commands
    always_comb
    begin
        logic bad;
        logic [1:0] cur;
        bad = 1'b0;
        cur = state_q.kind[cfg_bit];
        state_d = state_q;
        state_d.ack = 1'b0;
        state_d.rej = 1'b0;
        if (cfg_wr)
        begin
            // A bit must be released before it changes between fixed and switched
            if (cfg_kind != cwbs_pkg::KIND_NONE && reserved[cfg_bit])
                bad = 1'b1;                                                // see [R09] [R11]
            else if (cfg_kind == cwbs_pkg::KIND_FIXED && cur == cwbs_pkg::KIND_SWITCHED)
                bad = 1'b1;                                                // see [R07]
            else if (cfg_kind == cwbs_pkg::KIND_SWITCHED && cur == cwbs_pkg::KIND_FIXED)
                bad = 1'b1;                                                // see [R07]
            else if (cfg_kind == cwbs_pkg::KIND_FIXED && cfg_src == cwbs_pkg::SRC_TERM
                     && !term_ok[cfg_bit])
                bad = 1'b1;                                                // see [R08]
            else if (cfg_kind == cwbs_pkg::KIND_FIXED && cfg_src > cwbs_pkg::SRC_EMB)
                bad = 1'b1;
            else if (cfg_kind == 2'h3)
                bad = 1'b1;
            if (bad)
                state_d.rej = 1'b1;
            else
            begin
                state_d.ack = 1'b1;
                state_d.kind[cfg_bit] = cfg_kind;                          // see [R02]
                state_d.src[cfg_bit]  = cfg_src;
            end
        end
        state_d.func = routed;                                             // see [R16]
        state_d.ref2 = ref_sel2;
        state_d.cmd2 = cmd_sel2;
        // Run bits come from the active command channel, on every source
        state_d.fwd  = is_two ? word_bit(act_src, cwbs_pkg::FWD_BIT)
                              : (is_three & word_bit(act_src, cwbs_pkg::FWD3_BIT)); // see [R09]
        state_d.auth = is_three & word_bit(act_src, cwbs_pkg::AUTH_BIT);   // see [R11]
        if (is_two)
            state_d.rev = word_bit(act_src, cwbs_pkg::REV2_BIT);           // see [R10]
        else if (is_three)
            state_d.rev = word_bit(act_src, cwbs_pkg::REV3_BIT);           // see [R12]
        else
            state_d.rev = 1'b0;
    end

    // State register; reset clears every assignment
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < cwbs_pkg::CW_BITS; i++)
            begin
                state_q.kind[i] <= cwbs_pkg::KIND_RST;
                state_q.src[i]  <= cwbs_pkg::SRC_RST;
            end
            state_q.func <= 16'h0000;
            state_q.ref2 <= 1'b0;
            state_q.cmd2 <= 1'b0;
            state_q.fwd  <= 1'b0;
            state_q.auth <= 1'b0;
            state_q.rev  <= 1'b0;
            state_q.ack  <= 1'b0;
            state_q.rej  <= 1'b0;
        end
        else if (clk_en)
            state_q <= state_d;
    end

    // Outputs straight from the state register
    assign func_in                  = state_q.func;
    assign ref_ch2                  = state_q.ref2;
    assign cmd_ch2                  = state_q.cmd2;
    assign run_fwd                  = state_q.fwd;
    assign run_auth                 = state_q.auth;
    assign reverse_direction_assign = state_q.rev;
    assign cfg_ack                  = state_q.ack;
    assign cfg_reject               = state_q.rej;
endmodule // cwbs_top

//--- tb/cwbs_src_model.sv
// Far-side model: terminals, option card inputs and network control words
`timescale 1ns/100ps
module cwbs_src_model (
    input  wire logic        clk_sys, // Bench clock
    input  wire logic [15:0] pat,     // Source pattern from the bench
    input  wire logic [1:0]  fit,     // Cards fitted: bit 0 logic, bit 1 extended
    output logic      [5:0]  term_in, // Base terminals
    output logic      [3:0]  lc_in,   // Logic card inputs
    output logic      [3:0]  ec_in,   // Extended card inputs
    output logic      [15:0] cw_s,    // Serial word
    output logic      [15:0] cw_c,    // CAN word
    output logic      [15:0] cw_n,    // Network card word
    output logic      [15:0] cw_e     // Embedded card word
);
    logic [3:0] float_q = 4'h5;  // Pins of an absent card

    // Absent pins wander every cycle so a held stale level can never look right
    always @(negedge clk_sys) float_q <= ~float_q;
    // Each source differs so a wrong pick shows; any may carry a switch bit
    assign term_in = pat[5:0];
    assign lc_in   = fit[0] ? pat[9:6] : float_q;
    assign ec_in   = fit[1] ? pat[13:10] : float_q;
    assign cw_s    = pat ^ 16'h00ff;
    assign cw_c    = ~pat;
    assign cw_n    = {pat[7:0], pat[15:8]};
    assign cw_e    = pat ^ 16'h5a5a;
endmodule // cwbs_src_model

//--- tb/cwbs_top_sva.sv
// Assertion checker for the control word bit switching block
`timescale 1ns/100ps
module cwbs_top_sva (
    input wire logic        clk_sys,                  // System clock
    input wire logic        sys_rst,                  // Synchronous reset
    input wire logic        clk_en,                   // Clock enable
    input wire logic [5:0]  term_in,                  // Base terminals
    input wire logic [15:0] cw_serial,                // Serial word
    input wire logic [15:0] cw_can,                   // CAN word
    input wire logic [1:0]  run_style,                // Run style
    input wire logic        separate_mode,            // Separate mode
    input wire logic [2:0]  command_source_one,       // Channel 1 source
    input wire logic [1:0]  direct_reference_select,  // Reference switch mode
    input wire logic [3:0]  ref_sw_index,             // Reference switch order
    input wire logic [1:0]  command_channel_select,   // Command switch mode
    input wire logic        cfg_wr,                   // Write strobe
    input wire logic [3:0]  cfg_bit,                  // Written bit
    input wire logic [1:0]  cfg_kind,                 // Written kind
    input wire logic [2:0]  cfg_src,                  // Written source
    input wire logic [15:0] func_in,                  // Function inputs
    input wire logic        ref_ch2,                  // Reference on channel 2
    input wire logic        cmd_ch2,                  // Command on channel 2
    input wire logic        run_fwd,                  // Forward run
    input wire logic        run_auth,                 // Run authorization
    input wire logic        reverse_direction_assign, // Reverse command
    input wire logic        cfg_ack,                  // Write taken
    input wire logic        cfg_reject                // Write refused
);
    logic live_q;  // Outputs were refreshed at the last edge, outside reset

    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // Reset edges leave outputs at zero, so relations start one edge later
    always_ff @(posedge clk_sys) live_q <= clk_en && !sys_rst;

    sequence s_serial_active;
        live_q && !$past(separate_mode) && $past(direct_reference_select) == 2'h0
            && $past(command_source_one) == 3'h1;
    endsequence
    sequence s_fix_can4;
        clk_en && cfg_wr && cfg_kind == 2'h1 && cfg_src == 3'h2 && cfg_bit == 4'h4;
    endsequence

    property p_follow;
        live_q && !$past(separate_mode) |-> cmd_ch2 == ref_ch2;
    endproperty
    property p_ref_fix;
        live_q && !$past(direct_reference_select[1])
            |-> ref_ch2 == $past(direct_reference_select[0]);
    endproperty
    property p_ref_term;
        live_q && $past(direct_reference_select) == 2'h2 && $past(ref_sw_index) < 4'h6
            |-> ref_ch2 == $past(term_in[ref_sw_index]);
    endproperty
    property p_cmd_sep;
        live_q && $past(separate_mode) && !$past(command_channel_select[1])
            |-> cmd_ch2 == $past(command_channel_select[0]);
    endproperty
    property p_res2;
        live_q && $past(run_style) == 2'b01 |-> !func_in[0];
    endproperty
    property p_res3;
        live_q && $past(run_style) == 2'b10 |-> func_in[1:0] == 2'b00;
    endproperty
    property p_two_wire;
        s_serial_active ##0 $past(run_style) == 2'b01 |-> run_fwd == $past(cw_serial[0])
            && reverse_direction_assign == $past(cw_serial[1]) && !run_auth;
    endproperty
    property p_three_wire;
        s_serial_active ##0 $past(run_style) == 2'b10 |-> run_auth == $past(cw_serial[0])
            && run_fwd == $past(cw_serial[1]) && reverse_direction_assign == $past(cw_serial[2]);
    endproperty
    property p_fix_route;
        s_fix_can4 ##1 (cfg_ack && clk_en) |=> func_in[4] == $past(cw_can[4]);
    endproperty
    property p_cfg_answer;
        clk_en && cfg_wr |=> cfg_ack != cfg_reject;
    endproperty
    property p_res_write;
        clk_en && cfg_wr && cfg_kind != 2'h0 && run_style == 2'b01 && cfg_bit == 4'h0
            |=> cfg_reject;
    endproperty

    a_follow:     assert property (p_follow)
        else $error("command switch not following");
    a_ref_fix:    assert property (p_ref_fix)
        else $error("fixed reference switch wrong");
    a_ref_term:   assert property (p_ref_term)
        else $error("terminal reference switch wrong");
    a_cmd_sep:    assert property (p_cmd_sep)
        else $error("separate command switch wrong");
    a_res2:       assert property (p_res2)
        else $error("bit 0 not reserved");
    a_res3:       assert property (p_res3)
        else $error("bits 0 and 1 not reserved");
    a_two_wire:   assert property (p_two_wire)
        else $error("two-wire run outputs wrong");
    a_three_wire: assert property (p_three_wire)
        else $error("three-wire run outputs wrong");
    a_fix_route:  assert property (p_fix_route)
        else $error("fixed source not routed");
    a_cfg_answer: assert property (p_cfg_answer)
        else $error("write not answered once");
    a_res_write:  assert property (p_res_write)
        else $error("reserved bit write taken");
endmodule // cwbs_top_sva

bind cwbs_top cwbs_top_sva u_sva (.clk_sys, .sys_rst, .clk_en, .term_in, .cw_serial, .cw_can,
    .run_style, .separate_mode, .command_source_one, .direct_reference_select, .ref_sw_index,
    .command_channel_select, .cfg_wr, .cfg_bit, .cfg_kind, .cfg_src, .func_in, .ref_ch2,
    .cmd_ch2, .run_fwd, .run_auth, .reverse_direction_assign, .cfg_ack, .cfg_reject);

//--- tb/tb_top.sv
// Self-checking bench for control word bit switching
`timescale 1ns/100ps
module tb_top;
    logic        clk_sys = 1'b0, sys_rst = 1'b1, sep = 1'b0, cfg_wr = 1'b0, clk_en = 1'b1;
    logic [15:0] pat = 16'h0000, func_in, cw_s, cw_c, cw_n, cw_e, exp_func;
    logic [1:0]  fit = 2'b11, run_style = 2'b01, ref_sel = 2'h0, cmd_sel = 2'h0, cfg_kind = 2'h0;
    logic [2:0]  src1 = 3'h1, src2 = 3'h2, cfg_src = 3'h0;
    logic [3:0]  ref_idx = 4'h4, cfg_bit = 4'h0, lc_in, ec_in;
    logic [5:0]  term_in;
    logic        ref_ch2, cmd_ch2, run_fwd, run_auth, rev, ack, rej;
    logic [1:0]  kind_m [16];
    logic [2:0]  src_m [16];
    int          errors = 0, n_compared = 0, cycles = 0;

    always #2.5 clk_sys = ~clk_sys;

    cwbs_src_model u_src (.clk_sys(clk_sys), .pat(pat), .fit(fit), .term_in(term_in),
        .lc_in(lc_in), .ec_in(ec_in), .cw_s(cw_s), .cw_c(cw_c), .cw_n(cw_n), .cw_e(cw_e));
    cwbs_top uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .term_in(term_in),
        .logic_card_in(lc_in), .logic_card_fit(fit[0]), .ext_card_in(ec_in),
        .ext_card_fit(fit[1]), .cw_serial(cw_s), .cw_can(cw_c), .cw_net(cw_n), .cw_emb(cw_e),
        .run_style(run_style), .separate_mode(sep), .command_source_one(src1),
        .command_source_two(src2), .direct_reference_select(ref_sel), .ref_sw_index(ref_idx),
        .ref_sw_word(3'h2), .command_channel_select(cmd_sel), .cmd_sw_index(4'h0),
        .cmd_sw_word(3'h0), .cfg_wr(cfg_wr), .cfg_bit(cfg_bit), .cfg_kind(cfg_kind),
        .cfg_src(cfg_src), .func_in(func_in), .ref_ch2(ref_ch2), .cmd_ch2(cmd_ch2),
        .run_fwd(run_fwd), .run_auth(run_auth), .reverse_direction_assign(rev),
        .cfg_ack(ack), .cfg_reject(rej));

    // Our own view of each source, absent card inputs reading as zero
    function automatic logic [15:0] view(input logic [2:0] s);
        case (s)
            3'h0:    view = {2'h0, fit[1] ? pat[13:10] : 4'h0, fit[0] ? pat[9:6] : 4'h0, pat[5:0]};
            3'h1:    view = pat ^ 16'h00ff;
            3'h2:    view = ~pat;
            3'h3:    view = {pat[7:0], pat[15:8]};
            default: view = pat ^ 16'h5a5a;
        endcase
    endfunction

    task automatic cmp_word(input string name, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic cmp_bit(input string name, input logic e, input logic g);
        cmp_word(name, {15'h0000, e}, {15'h0000, g});
    endtask

    // One assignment write, then wait until it routes; one idle cycle between writes
    task automatic cfg(input logic [3:0] b, input logic [1:0] k, input logic [2:0] s,
                       input logic ok);
        cfg_wr = 1'b1;
        cfg_bit = b;
        cfg_kind = k;
        cfg_src = s;
        @(negedge clk_sys);
        cfg_wr = 1'b0;
        cmp_bit("cfg_ack", ok, ack);
        cmp_bit("cfg_reject", !ok, rej);
        if (ok)
        begin
            kind_m[b] = k;
            src_m[b] = s;
        end
        @(negedge clk_sys);
    endtask

    // Inputs already set at this falling edge; outputs are due at the next one
    task automatic check;
        logic        rc, cc;
        logic [15:0] a, f, e;
        a = view(ref_sel[0] ? 3'h2 : 3'h0);
        rc = ref_sel[1] ? a[ref_idx] : ref_sel[0];
        // Command switch by input or word code 0 reads terminal 0
        cc = sep ? (cmd_sel[1] ? pat[0] : cmd_sel[0]) : rc;
        a = view(cc ? src2 : src1);
        for (int n = 0; n < 16; n++)
        begin
            f = view(src_m[n]);
            e[n] = (kind_m[n] == 2'h2) ? a[n] : (kind_m[n] == 2'h1) ? f[n] : 1'b0;
        end
        e[1:0] = (run_style == 2'b10) ? 2'b00 : {e[1], 1'b0};
        exp_func = e;
        @(negedge clk_sys);
        cmp_word("func_in", e, func_in);
        cmp_bit("ref_ch2", rc, ref_ch2);
        cmp_bit("cmd_ch2", cc, cmd_ch2);
        cmp_bit("run_fwd", run_style[0] ? a[0] : a[1], run_fwd);
        cmp_bit("run_auth", run_style[1] & a[0], run_auth);
        cmp_bit("reverse", run_style[0] ? a[1] : a[2], rev);
    endtask

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // A hang is cut short well past the roughly 130 cycles the run needs
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            report_and_stop();
        end
    end

    initial
    begin
        for (int i = 0; i < 16; i++)
        begin
            kind_m[i] = 2'h0;
            src_m[i] = 3'h0;
        end
        repeat (20) @(negedge clk_sys);
        sys_rst = 1'b0;
        @(negedge clk_sys);
        cmp_word("func_in", 16'h0000, func_in);
        for (int b = 5; b < 16; b++)
            cfg(b[3:0], b[0] ? 2'h1 : 2'h2, 3'(b % 5), b != 15);
        cfg(4'h4, 2'h1, 3'h2, 1'b1);
        cfg(4'h3, 2'h2, 3'h0, 1'b1);
        cfg(4'h2, 2'h2, 3'h0, 1'b1);
        cfg(4'h2, 2'h1, 3'h1, 1'b0);
        cfg(4'h7, 2'h2, 3'h0, 1'b0);
        cfg(4'h1, 2'h1, 3'h1, 1'b1);
        cfg(4'h0, 2'h2, 3'h0, 1'b0);
        cfg(4'hf, 2'h3, 3'h0, 1'b0);
        cfg(4'hf, 2'h1, 3'h5, 1'b0);
        // Sweep sources, card fitting, switch modes and both run styles
        for (int r = 1; r < 3; r++)
            for (int i = 0; i < 32; i++)
            begin
                run_style = r[1:0];
                pat = (i[0] ? 16'h9e37 : 16'h61c8) ^ {4{i[3:0]}};
                fit = i[1:0];
                ref_sel = i[3:2];
                ref_idx = i[2] ? 4'h9 : 4'h4;
                sep = i[4];
                cmd_sel = i[1:0];
                src1 = 3'(i % 5);
                src2 = 3'((i + 2) % 5);
                check();
            end
        // A low enable must hold func_in although the sources all change
        clk_en = 1'b0;
        pat = ~pat;
        @(negedge clk_sys);
        cmp_word("func_in", exp_func, func_in);
        clk_en = 1'b1;
        report_and_stop();
    end
endmodule // tb_top
